// [logic/phy_mgmt_regs_loopback.sv]
// Management register bank for two PHY ports, with near-end and far-end loopback.
// Assumes the switch register file drives the sw* port on clk_sys; only mdc and mdioIn are pins.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs_loopback
	import phy_mgmt_pkg::*;
#(
	parameter int          SYM_W   = 5,
	parameter logic [15:0] ID_HIGH = 16'h0000, // Arbitrary identifier value
	parameter logic [15:0] ID_LOW  = 16'h0000  // Arbitrary identifier value
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             mdc,
	input  wire logic             mdioIn,
	output var  logic             mdioOut,
	output var  logic             mdioOe,
	input  wire logic             swWrEn,
	input  wire logic [7:0]       swAddr,
	input  wire logic [7:0]       swWrData,
	output var  logic [7:0]       swRdData,
	input  wire logic [15:0]      partnerAbility1,
	input  wire logic [15:0]      partnerAbility2,
	input  wire logic [15:0]      cableDiag1,
	input  wire logic [15:0]      cableDiag2,
	output var  logic [15:0]      phyCtrl1,
	output var  logic [15:0]      phyCtrl2,
	output var  logic             autonegRestart1,
	output var  logic             autonegRestart2,
	input  wire logic [SYM_W-1:0] rxSym1,
	input  wire logic [SYM_W-1:0] rxSym2,
	input  wire logic [SYM_W-1:0] pcsTxSym1,
	input  wire logic [SYM_W-1:0] pcsTxSym2,
	output var  logic [SYM_W-1:0] txSym1,
	output var  logic [SYM_W-1:0] txSym2
);

	mgmt_frame_if frame ();              // Engine to register bank

	// Per-port register state
	logic [15:0] ctrlQ [2];             // Basic control per port
	logic [15:0] advQ [2];              // Autoneg advertisement per port
	logic        nearLoopQ [2];         // Near-end loop per port
	logic        restartQ [2];          // Autoneg restart pulse per port
	// Management address decode
	logic [4:0]  phyBaseQ;              // Address of port 1; port 2 is next
	logic [4:0]  portAddr [2];          // Management address per port
	logic [1:0]  portHit;               // Frame address matches port
	logic        selPort;               // Addressed port index
	logic        mgmtWr [2];            // Management write to port
	// Read path
	logic [15:0] rdMux;                 // Read data of addressed register
	logic [15:0] ability [2];           // Partner ability per port
	logic [15:0] diag [2];              // Cable diagnostic status per port

	// Far-side status by port
	assign ability[0] = partnerAbility1;
	assign ability[1] = partnerAbility2;
	assign diag[0]    = cableDiag1;
	assign diag[1]    = cableDiag2;

	// Serial frame engine on the management pins
	// Pins in, frame fields out
	mdio_serial u_serial (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.mdc     (mdc),
		.mdioIn  (mdioIn),
		.mdioOut (mdioOut),
		.mdioOe  (mdioOe),
		.bus     (frame)
	);

	// Port addresses follow the programmable base
	assign portAddr[0] = phyBaseQ;
	assign portAddr[1] = phyBaseQ + 5'h01;
	assign portHit[0]  = (frame.phyAddr == portAddr[0]);
	assign portHit[1]  = (frame.phyAddr == portAddr[1]);
	// Port 1 wins if both addresses match
	assign selPort     = portHit[1] & ~portHit[0];
	assign frame.hit   = |portHit;
	// Each write reaches one port only
	assign mgmtWr[0]   = frame.wrStb & portHit[0];
	assign mgmtWr[1]   = frame.wrStb & portHit[1] & ~portHit[0];

	// Management read decode for the addressed port
	always_comb begin
		rdMux = 16'h0000; // Unsupported numbers read zero
		// Port index picks the per-port copy
		unique case (frame.regNum)
			REG_BASIC_CONTROL: rdMux = ctrlQ[selPort] & BC_STORE_MASK;
			REG_BASIC_STATUS:  rdMux = STATUS_VALUE;
			REG_ID_HIGH:       rdMux = ID_HIGH;
			REG_ID_LOW:        rdMux = ID_LOW;
			REG_AUTONEG_ADV:   rdMux = advQ[selPort];
			REG_PARTNER_AB:    rdMux = ability[selPort];
			REG_CABLE_DIAG:    rdMux = diag[selPort];
			REG_SPECIAL_CTRL: begin
				rdMux[SC_NEAR_LOOP] = nearLoopQ[selPort];
			end
			default: rdMux = 16'h0000;
		endcase
	end
	// Sampled at turnaround
	assign frame.rdata = rdMux;

	// Address base: reset default and switch reprogramming
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phyBaseQ <= PHY_BASE_RESET; // Port 1 at 1, port 2 at 2
		end else if (swWrEn && swAddr == SW_GLOBAL_13) begin
			// Port 2 follows at base plus one
			phyBaseQ <= swWrData[SW_ADDR_LSB +: 5];
		end
	end

	// Basic control storage, shared by the management and switch views
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < 2; p++) begin
				// Autoneg, crossover mode on
				ctrlQ[p] <= BC_RESET; // Autoneg on after reset
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				// Management beats switch
				if (mgmtWr[p] && frame.regNum == REG_BASIC_CONTROL) begin
					// Unsupported bits and restart are never stored
					ctrlQ[p] <= frame.wdata & BC_STORE_MASK;
				end else if (swWrEn && swAddr == SW_PORT_CTRL[p]) begin
					// Speed, autoneg and duplex mirror
					ctrlQ[p][BC_AUTONEG_ON]  <= swWrData[7];
					ctrlQ[p][BC_FORCE_100]   <= swWrData[6];
					ctrlQ[p][BC_FULL_DUPLEX] <= swWrData[5];
				end else if (swWrEn && swAddr == SW_PORT_DIAG[p]) begin
					// Far loop enable and port options mirror
					ctrlQ[p][BC_LOOPBACK]   <= swWrData[0];
					ctrlQ[p][BC_FORCE_MDI]  <= swWrData[1];
					ctrlQ[p][BC_DIS_MDIX]   <= swWrData[2];
					ctrlQ[p][BC_POWER_DOWN] <= swWrData[3];
					ctrlQ[p][BC_DIS_TX]     <= swWrData[6];
					ctrlQ[p][BC_DIS_LED]    <= swWrData[7];
					if (p == 0) begin
						// Far-end fault disable is mirrored from the switch map on port 1 only
						ctrlQ[p][BC_DIS_FEF] <= swWrData[4];
					end
				end else if (swWrEn && swAddr == SW_PORT_MDIX[p]) begin
					// Crossover mode mirror
					ctrlQ[p][BC_ALT_MDIX] <= swWrData[7];
				end
			end
		end
	end

	// Advertisement storage, management side only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < 2; p++) begin
				// Nothing advertised
				advQ[p] <= ADV_RESET;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (mgmtWr[p] && frame.regNum == REG_AUTONEG_ADV) begin
					// All sixteen bits are writable
					advQ[p] <= frame.wdata;
				end
			end
		end
	end

	// Near-end loop enable, one bit seen from both maps
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < 2; p++) begin
				// Loops off after reset
				nearLoopQ[p] <= 1'b0;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (mgmtWr[p] && frame.regNum == REG_SPECIAL_CTRL) begin
					// Management view; beats a switch write in the same cycle
					nearLoopQ[p] <= frame.wdata[SC_NEAR_LOOP];
				end else if (swWrEn && swAddr == SW_NEAR_LOOP[p]) begin
					// Switch map view of the same bit
					nearLoopQ[p] <= swWrData[1];
				end
			end
		end
	end

	// Autoneg restart: a write of one gives a single-cycle pulse, the bit self-clears
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < 2; p++) begin
				// No pulse pending
				restartQ[p] <= 1'b0;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				// High one cycle per write of one
				restartQ[p] <= (mgmtWr[p] && frame.regNum == REG_BASIC_CONTROL && frame.wdata[BC_RESTART_AN])
					|| (swWrEn && swAddr == SW_PORT_DIAG[p] && swWrData[5]);
			end
		end
	end

	// Switch-side readback of mirrored fields
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			swRdData <= 8'h00;
		end else begin
			swRdData <= 8'h00; // Unheld bits read zero
			// Address base field
			if (swAddr == SW_GLOBAL_13) begin
				swRdData[SW_ADDR_LSB +: 5] <= phyBaseQ;
			end
			for (int p = 0; p < 2; p++) begin
				if (swAddr == SW_NEAR_LOOP[p]) begin
					swRdData[1] <= nearLoopQ[p];
				end
				// Speed, autoneg and duplex
				if (swAddr == SW_PORT_CTRL[p]) begin
					swRdData[7:5] <= {ctrlQ[p][BC_AUTONEG_ON], ctrlQ[p][BC_FORCE_100], ctrlQ[p][BC_FULL_DUPLEX]};
				end
				// Restart bit always reads zero
				if (swAddr == SW_PORT_DIAG[p]) begin
					swRdData <= {ctrlQ[p][BC_DIS_LED], ctrlQ[p][BC_DIS_TX], 1'b0,
						(p == 0) ? ctrlQ[p][BC_DIS_FEF] : 1'b0, ctrlQ[p][BC_POWER_DOWN],
						ctrlQ[p][BC_DIS_MDIX], ctrlQ[p][BC_FORCE_MDI], ctrlQ[p][BC_LOOPBACK]};
				end
				// Crossover mode
				if (swAddr == SW_PORT_MDIX[p]) begin
					swRdData[7] <= ctrlQ[p][BC_ALT_MDIX];
				end
			end
		end
	end

	// Control outputs to the PHY cores
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phyCtrl1        <= BC_RESET;
			phyCtrl2        <= BC_RESET;
			autonegRestart1 <= 1'b0;
			autonegRestart2 <= 1'b0;
		end else begin
			// One stage keeps outputs on flops
			phyCtrl1        <= ctrlQ[0];
			phyCtrl2        <= ctrlQ[1];
			autonegRestart1 <= restartQ[0];
			autonegRestart2 <= restartQ[1];
		end
	end

	// Loops only forward symbols
	// Port 1 transmit: own near loop, or port 2's far loop turning port 1 traffic
	loopback_path #(
		.SYM_W (SYM_W)
	) u_loop1 (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.rxSym    (rxSym1),
		.pcsTxSym (pcsTxSym1),
		.nearEn   (nearLoopQ[0]),
		.farEn    (ctrlQ[1][BC_LOOPBACK]),
		.txSym    (txSym1)
	);

	// Port 2 transmit: own near loop, or port 1's far loop turning port 2 traffic
	loopback_path #(
		.SYM_W (SYM_W)
	) u_loop2 (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.rxSym    (rxSym2),
		.pcsTxSym (pcsTxSym2),
		.nearEn   (nearLoopQ[1]),
		.farEn    (ctrlQ[0][BC_LOOPBACK]),
		.txSym    (txSym2)
	);

endmodule
`default_nettype wire

// [inc/phy_mgmt_pkg.sv]
// Constants, register map and state codes for the PHY management register bank.
// Assumes one 100 MHz system clock; every switch register index is the 8-bit switch map.
`default_nettype none
package phy_mgmt_pkg;

	// Management register numbers
	localparam logic [4:0] REG_BASIC_CONTROL  = 5'h00;
	localparam logic [4:0] REG_BASIC_STATUS   = 5'h01;
	localparam logic [4:0] REG_ID_HIGH        = 5'h02;
	localparam logic [4:0] REG_ID_LOW         = 5'h03;
	localparam logic [4:0] REG_AUTONEG_ADV    = 5'h04;
	localparam logic [4:0] REG_PARTNER_AB     = 5'h05;
	localparam logic [4:0] REG_CABLE_DIAG     = 5'h1D;
	localparam logic [4:0] REG_SPECIAL_CTRL   = 5'h1F;

	// Basic control field positions
	localparam int BC_LOOPBACK    = 14;
	localparam int BC_FORCE_100   = 13;
	localparam int BC_AUTONEG_ON  = 12;
	localparam int BC_POWER_DOWN  = 11;
	localparam int BC_RESTART_AN  = 9;
	localparam int BC_FULL_DUPLEX = 8;
	localparam int BC_ALT_MDIX    = 5;
	localparam int BC_FORCE_MDI   = 4;
	localparam int BC_DIS_MDIX    = 3;
	localparam int BC_DIS_FEF     = 2;
	localparam int BC_DIS_TX      = 1;
	localparam int BC_DIS_LED     = 0;
	localparam int SC_NEAR_LOOP   = 1;

	// Stored bits of basic control; restart and unsupported bits are not held
	localparam logic [15:0] BC_STORE_MASK = 16'h793F;
	localparam logic [15:0] BC_RESET      = 16'h1020;
	localparam logic [15:0] STATUS_VALUE  = 16'h7000;
	localparam logic [15:0] ADV_RESET     = 16'h0000;

	// Switch register indices, port 1 then port 2
	localparam logic [7:0] SW_NEAR_LOOP [2] = '{8'h1A, 8'h2A};
	localparam logic [7:0] SW_PORT_CTRL [2] = '{8'h1C, 8'h2C};
	localparam logic [7:0] SW_PORT_DIAG [2] = '{8'h1D, 8'h2D};
	localparam logic [7:0] SW_PORT_MDIX [2] = '{8'h1F, 8'h2F};
	localparam logic [7:0] SW_GLOBAL_13     = 8'h0F;
	localparam int         SW_ADDR_LSB      = 3;
	localparam logic [4:0] PHY_BASE_RESET   = 5'h01;

	// Management frame timing in bits
	localparam logic [5:0] PRE_ONES  = 6'h20;
	localparam logic [4:0] HDR_LAST  = 5'h0C;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [1:0] OP_READ   = 2'h2;
	localparam logic [1:0] OP_WRITE  = 2'h1;

	// Frame engine states
	typedef enum logic [3:0] {
		ST_PRE  = 4'h1,
		ST_HDR  = 4'h2,
		ST_TA   = 4'h4,
		ST_DATA = 4'h8
	} mdio_state_e;

endpackage
`default_nettype wire

// [inc/mgmt_frame_if.sv]
// Carrier between the management frame engine and the register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface mgmt_frame_if;
	logic        wrStb;   // One-cycle write strobe
	logic [4:0]  phyAddr; // Addressed PHY
	logic [4:0]  regNum;  // Addressed register number
	logic [15:0] wdata;   // Write data
	logic [15:0] rdata;   // Read data for phyAddr/regNum
	logic        hit;     // phyAddr matches a port

	modport engine (output wrStb, phyAddr, regNum, wdata, input rdata, hit);
	modport regs   (input wrStb, phyAddr, regNum, wdata, output rdata, hit);
endinterface
`default_nettype wire

// [logic/mdio_serial.sv]
// Management serial frame engine: preamble, start, opcode, addresses, turnaround, data.
// Assumes mdc and mdioIn come from pins; both are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module mdio_serial
	import phy_mgmt_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	input  wire logic   mdc,
	input  wire logic   mdioIn,
	output var  logic   mdioOut,
	output var  logic   mdioOe,
	mgmt_frame_if.engine bus
);
	logic        mdcS1, mdcS2, mdcS3;   // Clock synchroniser and edge history
	logic        dinS1, dinS2;          // Data synchroniser
	logic        rise;                  // Management clock rising edge
	mdio_state_e stateQ;                // Frame position
	logic [5:0]  onesQ;                 // Preamble ones, saturating
	logic [4:0]  bitCntQ;               // Bit within field
	logic [15:0] shQ;                   // Shift register
	logic        readQ;                 // Frame is a read
	logic        hitQ;                  // Frame addresses this device
	logic [4:0]  phyQ, regQ;            // Captured addresses
	logic [15:0] wdataQ;                // Captured write data
	logic        wrStbQ;                // Write strobe
	logic [12:0] hdr;                   // Header including the current bit

	assign hdr         = {shQ[11:0], dinS2};
	assign rise        = mdcS2 & ~mdcS3;
	assign bus.phyAddr = phyQ;
	assign bus.regNum  = regQ;
	assign bus.wdata   = wdataQ;
	assign bus.wrStb   = wrStbQ;

	// Two-stage synchronisers for the pins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{mdcS1, mdcS2, mdcS3} <= 3'h0;
			{dinS1, dinS2}        <= 2'h3;
		end else begin
			mdcS1 <= mdc;
			mdcS2 <= mdcS1;
			mdcS3 <= mdcS2;
			dinS1 <= mdioIn;
			dinS2 <= dinS1;
		end
	end

	// Frame sequencer, advanced on each rising edge of the management clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stateQ  <= ST_PRE;
			onesQ   <= 6'h00;
			bitCntQ <= 5'h00;
			shQ     <= 16'h0000;
			readQ   <= 1'b0;
			hitQ    <= 1'b0;
			phyQ    <= 5'h00;
			regQ    <= 5'h00;
			wdataQ  <= 16'h0000;
			wrStbQ  <= 1'b0;
			mdioOut <= 1'b0;
			mdioOe  <= 1'b0;
		end else begin
			wrStbQ <= 1'b0;
			if (rise) begin
				unique case (stateQ)
					ST_PRE: begin
						// Count ones; a zero after a full preamble is the start bit
						if (dinS2) begin
							if (onesQ != PRE_ONES) onesQ <= onesQ + 6'h01;
						end else begin
							if (onesQ == PRE_ONES) begin
								stateQ  <= ST_HDR;
								bitCntQ <= 5'h00;
							end
							onesQ <= 6'h00;
						end
					end
					ST_HDR: begin
						shQ     <= {shQ[14:0], dinS2};
						bitCntQ <= bitCntQ + 5'h01;
						if (bitCntQ == HDR_LAST) begin
							bitCntQ <= 5'h00;
							phyQ    <= hdr[9:5];
							regQ    <= hdr[4:0];
							readQ   <= (hdr[11:10] == OP_READ);
							// Bad start or opcode drops back to preamble hunt
							if (hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
								stateQ <= ST_TA;
							end else begin
								stateQ <= ST_PRE;
							end
						end
					end
					ST_TA: begin
						bitCntQ <= bitCntQ + 5'h01;
						if (bitCntQ == 5'h00) begin
							// Second turnaround bit is driven low on a matching read
							hitQ <= bus.hit;
							shQ  <= bus.rdata;
							if (readQ && bus.hit) begin
								mdioOe  <= 1'b1;
								mdioOut <= 1'b0;
							end
						end else begin
							stateQ  <= ST_DATA;
							bitCntQ <= 5'h00;
							if (readQ && hitQ) begin
								mdioOut <= shQ[15];
								shQ     <= {shQ[14:0], 1'b0};
							end
						end
					end
					ST_DATA: begin
						bitCntQ <= bitCntQ + 5'h01;
						if (readQ) begin
							mdioOut <= shQ[15];
							shQ     <= {shQ[14:0], 1'b0};
						end else begin
							shQ <= {shQ[14:0], dinS2};
						end
						if (bitCntQ == DATA_LAST) begin
							// Release the line after the last read bit was sampled
							stateQ <= ST_PRE;
							mdioOe <= 1'b0;
							if (!readQ && hitQ) begin
								wdataQ <= {shQ[14:0], dinS2};
								wrStbQ <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [logic/loopback_path.sv]
// Per-port transmit selector at the PMD/PMA: normal transmit or the port's own receive symbols.
// Assumes symbols arrive on the system clock from the PMA.
`timescale 1ns/1ps
`default_nettype none
module loopback_path #(
	parameter int SYM_W = 5
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [SYM_W-1:0] rxSym,
	input  wire logic [SYM_W-1:0] pcsTxSym,
	input  wire logic             nearEn,
	input  wire logic             farEn,
	output var  logic [SYM_W-1:0] txSym
);
	// Either loop returns this port's receive stream on its transmit pair
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			txSym <= '0;
		end else if (nearEn || farEn) begin
			txSym <= rxSym;
		end else begin
			txSym <= pcsTxSym;
		end
	end
endmodule
`default_nettype wire

// [verification/mdio_master_model.sv]
// Station manager model: drives mdc and the management line, serial frames on demand.
// Assumes an 80 ns mdc period built from the 100 MHz system clock, and a pulled-up line.
`timescale 1ns/1ps
`default_nettype none
module mdio_master_model (
	input  wire logic clk_sys,
	input  wire logic mdioOut,
	input  wire logic mdioOe,
	output var  logic mdc,
	output wire logic mdioLine
);
	localparam logic [1:0] OP_WRITE_C = 2'h1; // Write opcode on the line
	logic drvEn;  // Manager drives the line
	logic drvBit; // Bit the manager drives

	initial begin
		mdc = 1'b0;
		drvEn = 1'b0;
		drvBit = 1'b1;
	end

	// Line level: device, manager, else the pull-up
	assign mdioLine = mdioOe ? mdioOut : (drvEn ? drvBit : 1'b1);

	// One whole frame; mdc stands low between frames
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
			input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		int i;
		bits = {32'hFFFF_FFFF, 2'b01, op, phy, regn, 2'b10, wd};
		rd = 16'h0000;
		for (i = 63; i >= 0; i--) begin
			@(posedge clk_sys);
			mdc <= 1'b0;
			// Released for turnaround and data of a read
			drvEn <= (op == OP_WRITE_C) || (i > 17);
			drvBit <= bits[i];
			repeat (4) @(posedge clk_sys);
			mdc <= 1'b1;
			if (i < 16) begin
				rd = {rd[14:0], mdioLine};
			end
			repeat (3) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		mdc <= 1'b0;
		drvEn <= 1'b0;
	endtask

endmodule
`default_nettype wire

// [verification/phy_mgmt_regs_loopback_properties.sv]
// Checker on the register bank ports: loop paths, switch mirrors, restart pulse, unheld bits.
// Assumes the single system clock and the active-low reset of the bank.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs_loopback_properties
	import phy_mgmt_pkg::*;
#(
	parameter int SYM_W = 5
) (
	input wire logic             clk_sys,
	input wire logic             rst_n,
	input wire logic             swWrEn,
	input wire logic [7:0]       swAddr,
	input wire logic [7:0]       swWrData,
	input wire logic [7:0]       swRdData,
	input wire logic [15:0]      phyCtrl1,
	input wire logic [15:0]      phyCtrl2,
	input wire logic             autonegRestart1,
	input wire logic             autonegRestart2,
	input wire logic             mdioOe,
	input wire logic [SYM_W-1:0] rxSym1,
	input wire logic [SYM_W-1:0] rxSym2,
	input wire logic [SYM_W-1:0] txSym1,
	input wire logic [SYM_W-1:0] txSym2
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic swMapped; // Switch index that the bank holds
	assign swMapped = swAddr inside {8'h0F, 8'h1A, 8'h1C, 8'h1D, 8'h1F, 8'h2A, 8'h2C, 8'h2D, 8'h2F};

	a_far_loop_one: assert property (phyCtrl1[BC_LOOPBACK] && $past(phyCtrl1[BC_LOOPBACK])
		|-> txSym2 == $past(rxSym2)) else $error("port 2 traffic not looped");
	a_far_loop_two: assert property (phyCtrl2[BC_LOOPBACK] && $past(phyCtrl2[BC_LOOPBACK])
		|-> txSym1 == $past(rxSym1)) else $error("port 1 traffic not looped");
	a_sw_far_alias: assert property (swWrEn && swAddr == 8'h2D
		|-> ##3 phyCtrl2[BC_LOOPBACK] == $past(swWrData[0], 3)) else $error("far loop mirror wrong");
	a_sw_autoneg: assert property (swWrEn && swAddr == 8'h1C
		|-> ##3 phyCtrl1[BC_AUTONEG_ON] == $past(swWrData[7], 3)) else $error("autoneg mirror wrong");
	a_sw_near_loop: assert property (swWrEn && swAddr == 8'h1A && swWrData[1]
		|-> ##3 txSym1 == $past(rxSym1)) else $error("near loop not active");
	a_restart_sw: assert property (swWrEn && swAddr == 8'h1D && swWrData[5]
		|-> ##[1:4] autonegRestart1) else $error("restart pulse missing");
	a_restart_single: assert property ($rose(autonegRestart2) |=> !autonegRestart2 [*2])
		else $error("restart pulse too long");
	a_unmapped_zero: assert property (!swMapped |=> swRdData == 8'h00)
		else $error("unmapped switch index read nonzero");
	a_ctrl_unheld: assert property (((phyCtrl1 | phyCtrl2) & ~BC_STORE_MASK) == 16'h0000)
		else $error("unheld control bit set");
	a_reset_ctrl: assert property ($rose(rst_n) |-> phyCtrl1 == BC_RESET && phyCtrl2 == BC_RESET)
		else $error("control reset value wrong");

	cover property (phyCtrl1[BC_LOOPBACK]);
	cover property (phyCtrl2[BC_LOOPBACK]);
	cover property ($rose(mdioOe));
	cover property (autonegRestart2);
endmodule

bind phy_mgmt_regs_loopback phy_mgmt_regs_loopback_properties #(.SYM_W(SYM_W)) chk (.clk_sys, .rst_n,
	.swWrEn, .swAddr, .swWrData, .swRdData, .phyCtrl1, .phyCtrl2, .autonegRestart1, .autonegRestart2,
	.mdioOe, .rxSym1, .rxSym2, .txSym1, .txSym2);
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the PHY register bank: management frames, switch writes, loop paths.
// Assumes the station manager model for the serial side; the bench drives the switch side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; \
	$display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
	import phy_mgmt_pkg::*;
	localparam logic [15:0] ID_H = 16'h5A3C; // Arbitrary identifier value
	localparam logic [15:0] ID_L = 16'hC3A5; // Arbitrary identifier value
	logic        clk_sys, rst_n, mdc, mdioIn, mdioOut, mdioOe, swWrEn;
	logic [7:0]  swAddr, swWrData, swRdData;
	logic [15:0] partnerAbility1, partnerAbility2, cableDiag1, cableDiag2, phyCtrl1, phyCtrl2;
	logic        autonegRestart1, autonegRestart2;
	logic [4:0]  rxSym1, rxSym2, pcsTxSym1, pcsTxSym2, txSym1, txSym2;
	logic [15:0] rd, wv; // Read word, written word
	int          errorCnt, checked, cycles, r;

	phy_mgmt_regs_loopback #(.SYM_W(5), .ID_HIGH(ID_H), .ID_LOW(ID_L)) dut (.clk_sys, .rst_n, .mdc,
		.mdioIn, .mdioOut, .mdioOe, .swWrEn, .swAddr, .swWrData, .swRdData, .partnerAbility1,
		.partnerAbility2, .cableDiag1, .cableDiag2, .phyCtrl1, .phyCtrl2, .autonegRestart1,
		.autonegRestart2, .rxSym1, .rxSym2, .pcsTxSym1, .pcsTxSym2, .txSym1, .txSym2);
	mdio_master_model mgmt (.clk_sys, .mdioOut, .mdioOe, .mdc, .mdioLine(mdioIn));

	always #5 clk_sys = ~clk_sys;

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 50000) begin
			errorCnt++;
			end_of_test();
		end
	end

	// Reset-state readback of a register number
	function automatic logic [15:0] expReg(input int n, input logic [15:0] pa, input logic [15:0] cd);
		case (5'(n))
			REG_BASIC_CONTROL: return BC_RESET;
			REG_BASIC_STATUS: return STATUS_VALUE;
			REG_ID_HIGH: return ID_H;
			REG_ID_LOW: return ID_L;
			REG_AUTONEG_ADV: return ADV_RESET;
			REG_PARTNER_AB: return pa;
			REG_CABLE_DIAG: return cd;
			default: return 16'h0000;
		endcase
	endfunction

	task automatic swWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		swAddr <= a;
		swWrData <= d;
		swWrEn <= 1'b1;
		@(posedge clk_sys);
		swWrEn <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic swCheck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		swAddr <= a;
		repeat (2) @(posedge clk_sys);
		#1 `CHK(swRdData & m, e)
	endtask

	// Random symbols; each port expects its receive or its PCS symbols back
	task automatic loopCheck(input logic l1, input logic l2);
		logic [4:0] r1, r2, p1, p2;
		repeat (10) begin
			@(posedge clk_sys);
			{r1, r2, p1, p2} = {rxSym1, rxSym2, pcsTxSym1, pcsTxSym2};
			{rxSym1, rxSym2, pcsTxSym1, pcsTxSym2} <= 20'($urandom);
			#1 `CHK(txSym1, l1 ? r1 : p1)
			`CHK(txSym2, l2 ? r2 : p2)
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", errorCnt, checked);
		if (errorCnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		void'($urandom(35663));
		{clk_sys, rst_n, swWrEn, swAddr, swWrData} = '0;
		{rxSym1, rxSym2, pcsTxSym1, pcsTxSym2} = '0;
		{partnerAbility1, partnerAbility2, cableDiag1, cableDiag2} = {$urandom, $urandom};
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// Whole register map of port 1, and the cable diagnostic input of port 2
		for (r = 0; r < 32; r++) begin
			mgmt.frame(OP_READ, 5'h01, 5'(r), 16'h0000, rd);
			`CHK(rd, expReg(r, partnerAbility1, cableDiag1))
		end
		mgmt.frame(OP_READ, 5'h02, REG_CABLE_DIAG, 16'h0000, rd);
		`CHK(rd, cableDiag2)
		mgmt.frame(OP_READ, 5'h03, REG_BASIC_STATUS, 16'h0000, rd);
		`CHK(rd, 16'hFFFF)
		// Writes: read-write, read-only and missing numbers
		wv = 16'($urandom);
		mgmt.frame(OP_WRITE, 5'h02, REG_AUTONEG_ADV, wv, rd);
		mgmt.frame(OP_READ, 5'h02, REG_AUTONEG_ADV, 16'h0000, rd);
		`CHK(rd, wv)
		mgmt.frame(OP_WRITE, 5'h01, REG_BASIC_STATUS, 16'hFFFF, rd);
		mgmt.frame(OP_READ, 5'h01, REG_BASIC_STATUS, 16'h0000, rd);
		`CHK(rd, STATUS_VALUE)
		mgmt.frame(OP_WRITE, 5'h01, 5'h1E, 16'hFFFF, rd);
		mgmt.frame(OP_READ, 5'h01, 5'h1E, 16'h0000, rd);
		`CHK(rd, 16'h0000)
		// Both ports forced to 100 Mbps, far loop on port 1 through control bit 14
		mgmt.frame(OP_WRITE, 5'h02, REG_BASIC_CONTROL, 16'h2000, rd);
		mgmt.frame(OP_WRITE, 5'h01, REG_BASIC_CONTROL, 16'h6000, rd);
		repeat (4) @(posedge clk_sys);
		`CHK(phyCtrl1, 16'h6000)
		loopCheck(1'b0, 1'b1);
		swCheck(8'h1D, 8'hFF, 8'h01);
		// Far loop off; near loop on port 2 through register 31
		mgmt.frame(OP_WRITE, 5'h01, REG_BASIC_CONTROL, 16'h2000, rd);
		mgmt.frame(OP_WRITE, 5'h02, REG_SPECIAL_CTRL, 16'h0002, rd);
		mgmt.frame(OP_READ, 5'h02, REG_SPECIAL_CTRL, 16'h0000, rd);
		`CHK(rd, 16'h0002)
		loopCheck(1'b0, 1'b1);
		swCheck(8'h2A, 8'h02, 8'h02);
		// Switch side: near loop port 1, then far loop of port 2
		swWrite(8'h2A, 8'h00);
		swWrite(8'h1A, 8'h02);
		loopCheck(1'b1, 1'b0);
		swWrite(8'h1A, 8'h00);
		swWrite(8'h2D, 8'h01);
		loopCheck(1'b1, 1'b0);
		`CHK(phyCtrl2[BC_LOOPBACK], 1'b1)
		swWrite(8'h2D, 8'h00);
		swWrite(8'h1C, 8'h80);
		mgmt.frame(OP_READ, 5'h01, REG_BASIC_CONTROL, 16'h0000, rd);
		`CHK(rd[BC_AUTONEG_ON], 1'b1)
		swWrite(8'h1D, 8'h20);
		// Restart through management: one pulse, bit reads back 0
		fork
			mgmt.frame(OP_WRITE, 5'h02, REG_BASIC_CONTROL, 16'h2200, rd);
			begin
				r = 0;
				while (autonegRestart2 !== 1'b1 && r < 2000) begin
					@(posedge clk_sys);
					#1 r++;
				end
				`CHK(autonegRestart2, 1'b1)
			end
		join
		mgmt.frame(OP_READ, 5'h02, REG_BASIC_CONTROL, 16'h0000, rd);
		`CHK(rd, 16'h2000)
		// Addresses moved to 5 and 6
		swWrite(8'h0F, 8'h28);
		mgmt.frame(OP_READ, 5'h05, REG_BASIC_STATUS, 16'h0000, rd);
		`CHK(rd, STATUS_VALUE)
		mgmt.frame(OP_READ, 5'h06, REG_AUTONEG_ADV, 16'h0000, rd);
		`CHK(rd, wv)
		mgmt.frame(OP_READ, 5'h01, REG_BASIC_STATUS, 16'h0000, rd);
		`CHK(rd, 16'hFFFF)
		mgmt.frame(OP_WRITE, 5'h05, REG_BASIC_CONTROL, 16'hFFFF, rd);
		mgmt.frame(OP_READ, 5'h05, REG_BASIC_CONTROL, 16'h0000, rd);
		`CHK(rd, BC_STORE_MASK)
		// Reset in mid-run restores addresses and control
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		mgmt.frame(OP_READ, 5'h01, REG_BASIC_CONTROL, 16'h0000, rd);
		`CHK(rd, BC_RESET)
		end_of_test();
	end
endmodule
`default_nettype wire
